/* File: common/ltc_pkg.sv */
package ltc_pkg;

  // Bus geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // Register indices and byte addresses
  localparam int AC_IDX   = 'h1e;
  localparam int C5_IDX   = 'h1f;
  localparam int STAT_IDX = 'h30;
  localparam logic [APB_AW-1:0] AC_ADDR   = APB_AW'(AC_IDX * 4);
  localparam logic [APB_AW-1:0] C5_ADDR   = APB_AW'(C5_IDX * 4);
  localparam logic [APB_AW-1:0] STAT_ADDR = APB_AW'(STAT_IDX * 4);

  // Values after reset
  localparam logic [7:0] AC_RST = 8'h00;
  localparam logic [7:0] C5_RST = 8'h20;

  // Writable bits of the AC termination register
  localparam logic [7:0] AC_WR_MASK = 8'h3f;

  // Field positions
  localparam int AC_DBL_BIT  = 4;
  localparam int AC_IMP_LSB  = 0;
  localparam int C5_RSE_BIT  = 7;
  localparam int C5_FOH_LSB  = 5;
  localparam int C5_ONHOOK_SPEED_SECOND_BIT = 3;
  localparam int C5_RECEIVE_CORNER_SELECT_BIT = 1;
  localparam int C5_LINE_VOLTAGE_ZERO_FORCE_DISABLE_BIT = 0;

  // Field codes
  localparam logic [3:0] IMP_GLOBAL = 4'hf;
  localparam logic [1:0] FOH_512    = 2'h0;
  localparam logic [1:0] FOH_128    = 2'h1;
  localparam logic [1:0] FOH_64     = 2'h2;
  localparam logic [1:0] FOH_8      = 2'h3;
  localparam logic [1:0] SQ_SLOW    = 2'h3;
  localparam logic [1:0] ADJ_TOP    = 2'h3;
  localparam logic [1:0] MINI_LOW   = 2'h0;

  // Line voltage forcing window, one count per volt
  localparam logic signed [7:0] LV_FORCE_HI = 8'sh03;
  localparam logic signed [7:0] LV_FORCE_LO = 8'shfd;

  // Timing
  localparam int CLK_KHZ     = 40000;
  localparam int OFF_512_MS  = 512;
  localparam int OFF_128_MS  = 128;
  localparam int OFF_64_MS   = 64;
  localparam int OFF_8_MS    = 8;
  localparam int ON_FAST_US  = 500;
  localparam int ON_ETSI_MS  = 3;
  localparam int ON_SPARK_MS = 26;
  localparam int OFF_512_CYC  = OFF_512_MS * CLK_KHZ;
  localparam int OFF_128_CYC  = OFF_128_MS * CLK_KHZ;
  localparam int OFF_64_CYC   = OFF_64_MS * CLK_KHZ;
  localparam int OFF_8_CYC    = OFF_8_MS * CLK_KHZ;
  localparam int ON_FAST_CYC  = (ON_FAST_US * CLK_KHZ) / 1000;
  localparam int ON_ETSI_CYC  = ON_ETSI_MS * CLK_KHZ;
  localparam int ON_SPARK_CYC = ON_SPARK_MS * CLK_KHZ;
  localparam int CNT_W        = 25;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } ltc_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
  } ltc_apb_rsp_t;

  typedef struct packed {
    logic       double_scale_mode;
    logic       raised_scale_mode;
    logic [3:0] ac_impedance_select;
    logic       impedance_global;
    logic [1:0] offhook_counter_length;
    logic       onhook_speed_second;
    logic       receive_corner_select;
    logic       line_voltage_zero_force_disable;
    logic       pin_voltage_top;
    logic       scale_setup_ok;
  } ltc_cfg_t;

  localparam ltc_cfg_t CFG_RST = '{
    offhook_counter_length: C5_RST[6:5],
    scale_setup_ok:         1'b1,
    default:                '0
  };

endpackage

/* File: core/ltc_countdown.sv */
`timescale 1ns/1ps
module ltc_countdown (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // Control
  input  wire logic                      start,
  input  wire logic [ltc_pkg::CNT_W-1:0] load,
  // Status
  output      logic                      busy,
  output      logic                      done
);
  import ltc_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
  } ltc_cd_state_t;

  ltc_cd_state_t st_r;
  ltc_cd_state_t st_nxt;

  // Busy stays high for exactly load cycles; a zero load counts as one
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      st_nxt.cnt  = (load == '0) ? CNT_W'(1) : load;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.cnt == CNT_W'(1)) begin
        st_nxt.cnt  = '0;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_load_busy: assert property ( // RULE7
    start && load != '0 |=> busy && st_r.cnt == $past(load))
    else $error("timer did not load its length");

  chk_count_down: assert property ( // RULE7
    busy && st_r.cnt > CNT_W'(1) && !start
      |=> busy && st_r.cnt == $past(st_r.cnt) - CNT_W'(1))
    else $error("timer did not count down by one");

  chk_end_pulse: assert property ( // RULE9
    busy && st_r.cnt == CNT_W'(1) && !start |=> !busy && done ##1 !done)
    else $error("timer end is not a single done pulse");

endmodule

/* File: core/ltc_line_term_regs.sv */
// Overview of operation
// RULE1: AC register bit 4 selects doubled transmit/receive full scale, else default.
// RULE2: Software sets voltage adjust to all ones when doubled scale is on.
// RULE3: AC bits 3:0 select off-hook termination; 1111 selects global impedance.
// RULE4: Reduced line-side variant: software writes zero to impedance bits 3:2, 0.
// RULE5: Control-5 bit 7 raises converter full scale to +3.2 dBm.
// RULE6: With raised scale, software sets adjust all ones, minimum current zero.
// RULE7: Control-5 bits 6:5 pick off-hook count 512/128/64/8 ms; reset 01.
// RULE8: Software writes zero to control-5 reserved bits 4 and 2.
// RULE9: Speed bits and spark quench pick on-hook time: 0.5, 3, 26 ms.
// RULE10: Control-5 bit 1 puts receive corner at 5 Hz or 200 Hz.
// RULE11: Bit 0 clear forces line voltage to zero at 3 V or less.
// RULE12: Line voltage reading is 8-bit two's complement, one volt per count.
// RULE13: Voltage adjust code all ones selects the highest pin voltage.
// RULE14: AC bits 7:6 read zero; bit 5 takes any value harmlessly.
`timescale 1ns/1ps
module ltc_line_term_regs #(
  parameter int unsigned OFF_512_P  = ltc_pkg::OFF_512_CYC,
  parameter int unsigned OFF_128_P  = ltc_pkg::OFF_128_CYC,
  parameter int unsigned OFF_64_P   = ltc_pkg::OFF_64_CYC,
  parameter int unsigned OFF_8_P    = ltc_pkg::OFF_8_CYC,
  parameter int unsigned ON_FAST_P  = ltc_pkg::ON_FAST_CYC,
  parameter int unsigned ON_ETSI_P  = ltc_pkg::ON_ETSI_CYC,
  parameter int unsigned ON_SPARK_P = ltc_pkg::ON_SPARK_CYC
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // APB slave
  input  wire ltc_pkg::ltc_apb_req_t apb_req,
  output      ltc_pkg::ltc_apb_rsp_t apb_rsp,
  // Settings held in neighbouring registers
  input  wire logic                  hook_control_bit,
  input  wire logic                  onhook_speed_first,
  input  wire logic [1:0]            spark_quench_select,
  input  wire logic [1:0]            tip_ring_voltage_adjust,
  input  wire logic [1:0]            minimum_loop_current,
  // Line voltage sense
  input  wire logic [7:0]            line_voltage_raw,
  output      logic [7:0]            line_voltage_reading,
  // Settings to the line side
  output      ltc_pkg::ltc_cfg_t     cfg,
  // Hook sequencing
  output      logic                  offhook_busy,
  output      logic                  offhook_settled,
  output      logic                  loop_release_active
);
  import ltc_pkg::*;

  typedef struct packed {
    ltc_apb_rsp_t rsp;
    logic [7:0]   ac_reg;
    logic [7:0]   c5_reg;
    ltc_cfg_t     cfg;
    logic         hook_q;
    logic         settled;
    logic [7:0]   lv;
  } ltc_top_state_t;

  ltc_top_state_t    st_r;
  ltc_top_state_t    st_nxt;
  logic              setup;
  logic              wr;
  logic              wr_ac;
  logic              wr_c5;
  logic              off_start;
  logic              on_start;
  logic              off_done;
  logic [CNT_W-1:0]  off_load;
  logic [CNT_W-1:0]  on_load;
  logic signed [7:0] lv_s;
  logic              lv_force;
  logic              scale_ok;
  logic [7:0]        stat_byte;

  // Bus phase decode
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr    = apb_req.psel && apb_req.penable && st_r.rsp.pready
                 && apb_req.pwrite;
  assign wr_ac = wr && apb_req.paddr == AC_ADDR;
  assign wr_c5 = wr && apb_req.paddr == C5_ADDR;

  // Hook edges start the two sequencing timers
  assign off_start = hook_control_bit && !st_r.hook_q;
  assign on_start  = !hook_control_bit && st_r.hook_q;

  // Line voltage forcing near zero volts
  assign lv_s     = line_voltage_raw;
  assign lv_force = !st_r.cfg.line_voltage_zero_force_disable   // RULE11
                    && lv_s >= LV_FORCE_LO && lv_s <= LV_FORCE_HI;

  // Full-scale modes only run cleanly with matching loop settings
  assign scale_ok =
    (!st_r.cfg.double_scale_mode || tip_ring_voltage_adjust == ADJ_TOP)
    && (!st_r.cfg.raised_scale_mode
        || (tip_ring_voltage_adjust == ADJ_TOP
            && minimum_loop_current == MINI_LOW));

  assign stat_byte = {3'h0, st_r.cfg.pin_voltage_top, st_r.cfg.scale_setup_ok,
                      loop_release_active, offhook_busy, st_r.settled};

  // Off-hook counter length
  always_comb begin
    case (st_r.cfg.offhook_counter_length)                      // RULE7
      FOH_512: off_load = CNT_W'(OFF_512_P);
      FOH_128: off_load = CNT_W'(OFF_128_P);
      FOH_64:  off_load = CNT_W'(OFF_64_P);
      default: off_load = CNT_W'(OFF_8_P);
    endcase
  end

  // On-hook release time, hook clear to zero loop current
  always_comb begin
    if (onhook_speed_first && spark_quench_select == SQ_SLOW) begin // RULE9
      on_load = CNT_W'(ON_SPARK_P);
    end else if (!onhook_speed_first && st_r.cfg.onhook_speed_second) begin
      on_load = CNT_W'(ON_ETSI_P);
    end else begin
      on_load = CNT_W'(ON_FAST_P);
    end
  end

  always_comb begin
    st_nxt = st_r;

    // Register writes take effect at the completing access edge
    if (wr_ac) begin
      st_nxt.ac_reg = apb_req.pwdata[7:0] & AC_WR_MASK;         // RULE14
    end else if (wr_c5) begin
      st_nxt.c5_reg = apb_req.pwdata[7:0];
    end

    // Settings other than scale_setup_ok and pin_voltage_top follow the register contents in the same cycle
    st_nxt.cfg.double_scale_mode   = st_nxt.ac_reg[AC_DBL_BIT];  // RULE1
    st_nxt.cfg.ac_impedance_select =
      st_nxt.ac_reg[AC_IMP_LSB +: 4];                           // RULE3
    st_nxt.cfg.impedance_global    =
      st_nxt.ac_reg[AC_IMP_LSB +: 4] == IMP_GLOBAL;             // RULE3
    st_nxt.cfg.raised_scale_mode   = st_nxt.c5_reg[C5_RSE_BIT];  // RULE5
    st_nxt.cfg.offhook_counter_length =
      st_nxt.c5_reg[C5_FOH_LSB +: 2];                           // RULE7
    st_nxt.cfg.onhook_speed_second = st_nxt.c5_reg[C5_ONHOOK_SPEED_SECOND_BIT]; // RULE9
    st_nxt.cfg.receive_corner_select =
      st_nxt.c5_reg[C5_RECEIVE_CORNER_SELECT_BIT];                               // RULE10
    st_nxt.cfg.line_voltage_zero_force_disable =
      st_nxt.c5_reg[C5_LINE_VOLTAGE_ZERO_FORCE_DISABLE_BIT];                               // RULE11
    st_nxt.cfg.pin_voltage_top =
      tip_ring_voltage_adjust == ADJ_TOP;                       // RULE13
    st_nxt.cfg.scale_setup_ok = scale_ok;

    // Line voltage, passed through as a signed volt count
    st_nxt.lv = lv_force ? 8'h00 : line_voltage_raw;            // RULE12

    // Hook tracking; the hook falling wins over a finished count
    st_nxt.hook_q = hook_control_bit;
    if (off_done && hook_control_bit) begin
      st_nxt.settled = 1'b1;
    end else if (!hook_control_bit || off_start) begin
      st_nxt.settled = 1'b0;
    end

    // Answer one cycle after setup; no wait states
    st_nxt.rsp.pready  = setup;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata  = '0;
    if (setup) begin
      if (apb_req.paddr == AC_ADDR) begin
        st_nxt.rsp.prdata = {24'h0, st_r.ac_reg & AC_WR_MASK}; // RULE14
      end else if (apb_req.paddr == C5_ADDR) begin
        st_nxt.rsp.prdata = {24'h0, st_r.c5_reg};
      end else if (apb_req.paddr == STAT_ADDR) begin
        st_nxt.rsp.prdata = {24'h0, stat_byte};
      end else begin
        st_nxt.rsp.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r        <= '0;
      st_r.ac_reg <= AC_RST;
      st_r.c5_reg <= C5_RST;
      st_r.cfg    <= CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ltc_countdown u_offhook (
    .mclk  (mclk),
    .rst_b (rst_b),
    .start (off_start),
    .load  (off_load),
    .busy  (offhook_busy),
    .done  (off_done)
  );

  ltc_countdown u_onhook (
    .mclk  (mclk),
    .rst_b (rst_b),
    .start (on_start),
    .load  (on_load),
    .busy  (loop_release_active),
    .done  ()
  );

  assign apb_rsp              = st_r.rsp;
  assign cfg                  = st_r.cfg;
  assign line_voltage_reading = st_r.lv;
  assign offhook_settled      = st_r.settled;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_setup_ac_read;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == AC_ADDR;
  endsequence

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  chk_double_scale: assert property ( // RULE1
    wr_ac |=> cfg.double_scale_mode == $past(apb_req.pwdata[AC_DBL_BIT]))
    else $error("doubled scale does not follow the write");

  chk_imp_code: assert property ( // RULE3
    wr_ac |=> cfg.ac_impedance_select == $past(apb_req.pwdata[3:0])
      && cfg.impedance_global == ($past(apb_req.pwdata[3:0]) == IMP_GLOBAL))
    else $error("impedance code does not follow the write");

  chk_raised_scale: assert property ( // RULE5
    wr_c5 |=> cfg.raised_scale_mode == $past(apb_req.pwdata[C5_RSE_BIT]))
    else $error("raised scale does not follow the write");

  chk_fast_offhook: assert property ( // RULE7
    off_start && cfg.offhook_counter_length == FOH_8
      |-> off_load == CNT_W'(OFF_8_P) ##1 offhook_busy)
    else $error("shortest off-hook count not chosen");

  chk_spark_onhook: assert property ( // RULE9
    on_start && onhook_speed_first && spark_quench_select == SQ_SLOW
      |-> on_load == CNT_W'(ON_SPARK_P) ##1 loop_release_active)
    else $error("spark quench release time not chosen");

  chk_corner_sel: assert property ( // RULE10
    wr_c5 |=> cfg.receive_corner_select == $past(apb_req.pwdata[1])
      ##1 cfg.receive_corner_select == $past(apb_req.pwdata[1], 2))
    else $error("receive corner does not follow the write");

  chk_lv_force: assert property ( // RULE11
    !cfg.line_voltage_zero_force_disable && lv_s >= LV_FORCE_LO
      && lv_s <= LV_FORCE_HI |=> line_voltage_reading == 8'h00)
    else $error("small line voltage was not forced to zero");

  chk_lv_pass: assert property ( // RULE12
    cfg.line_voltage_zero_force_disable
      |=> line_voltage_reading == $past(line_voltage_raw))
    else $error("line voltage not passed through");

  chk_pin_top: assert property ( // RULE13
    tip_ring_voltage_adjust == ADJ_TOP |=> cfg.pin_voltage_top)
    else $error("top pin voltage not flagged");

  chk_resv_read: assert property ( // RULE14
    s_setup_ac_read ##1 s_access
      |-> apb_rsp.pready && apb_rsp.prdata[31:6] == '0)
    else $error("reserved AC bits read nonzero");

  chk_settle_hold: assert property ( // RULE7
    off_done && hook_control_bit |=> offhook_settled)
    else $error("off-hook count end not reported");

  chk_foh_512: assert property ( // RULE7
    off_start && cfg.offhook_counter_length == FOH_512
      |-> off_load == CNT_W'(OFF_512_P) ##1 offhook_busy)
    else $error("longest off-hook count not chosen");

  chk_foh_128: assert property ( // RULE7
    off_start && cfg.offhook_counter_length == FOH_128
      |-> off_load == CNT_W'(OFF_128_P) ##1 offhook_busy)
    else $error("default off-hook count not chosen");

  chk_foh_64: assert property ( // RULE7
    off_start && cfg.offhook_counter_length == FOH_64
      |-> off_load == CNT_W'(OFF_64_P) ##1 offhook_busy)
    else $error("short off-hook count not chosen");

  chk_etsi_onhook: assert property ( // RULE9
    on_start && !onhook_speed_first && cfg.onhook_speed_second
      && spark_quench_select == 2'h0
      |-> on_load == CNT_W'(ON_ETSI_P) ##1 loop_release_active)
    else $error("medium release time not chosen");

  chk_fast_onhook: assert property ( // RULE9
    on_start && !onhook_speed_first && !cfg.onhook_speed_second
      && spark_quench_select == 2'h0
      |-> on_load == CNT_W'(ON_FAST_P) ##1 loop_release_active)
    else $error("fast release time not chosen");

  chk_lv_zero: assert property ( // RULE11
    cfg.line_voltage_zero_force_disable && line_voltage_raw == 8'h00
      |=> line_voltage_reading == 8'h00)
    else $error("zero line voltage not read as zero");

endmodule

/* File: verif/ltc_line_term_regs_tb_top.sv */
`timescale 1ns/1ps
module ltc_line_term_regs_tb_top;
  import ltc_pkg::*;

  // Shortened timer lengths so that every hook sequence runs quickly
  localparam int         OFF_T0 = 40;
  localparam int         OFF_T1 = 30;
  localparam int         OFF_T2 = 20;
  localparam int         OFF_T3 = 10;
  localparam int         ON_T0  = 5;
  localparam int         ON_T1  = 8;
  localparam int         ON_T2  = 12;
  localparam int         OFF_LEN [4] = '{OFF_T0, OFF_T1, OFF_T2, OFF_T3};
  localparam logic       ON_FST  [5] = '{0, 0, 1, 1, 0};
  localparam logic       ON_SEC  [5] = '{0, 1, 0, 1, 0};
  localparam logic [1:0] ON_Q    [5] = '{0, 0, 3, 3, 3};
  localparam int         ON_LEN  [5] = '{ON_T0, ON_T1, ON_T2, ON_T2, ON_T0};
  localparam logic       LV_DIS  [8] = '{0, 0, 0, 0, 0, 1, 1, 1};
  localparam logic [7:0] LV_IN   [8] = '{3, 8'hfd, 4, 8'hfc, 0, 2, 8'hfe, 0};
  localparam logic [7:0] LV_EXP  [8] = '{0, 0, 4, 8'hfc, 0, 2, 8'hfe, 0};

  logic         mclk;
  logic         rst_b;
  logic         hook;
  logic         first;
  logic [1:0]   quench;
  logic [1:0]   adj;
  logic [1:0]   mini;
  logic [7:0]   raw;
  logic [7:0]   lv;
  ltc_apb_req_t req;
  ltc_apb_rsp_t rsp;
  ltc_cfg_t     cfg;
  logic         busy;
  logic         settled;
  logic         rel;
  logic [31:0]  rd;
  logic         er;
  int           err_total;
  int           comparisons;
  int           cyc = 0;
  int           n;

  ltc_line_term_regs #(
    .OFF_512_P(OFF_T0), .OFF_128_P(OFF_T1), .OFF_64_P(OFF_T2),
    .OFF_8_P(OFF_T3), .ON_FAST_P(ON_T0), .ON_ETSI_P(ON_T1),
    .ON_SPARK_P(ON_T2)
  ) DUT (
    .mclk(mclk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .hook_control_bit(hook), .onhook_speed_first(first),
    .spark_quench_select(quench), .tip_ring_voltage_adjust(adj),
    .minimum_loop_current(mini), .line_voltage_raw(raw),
    .line_voltage_reading(lv), .cfg(cfg), .offhook_busy(busy),
    .offhook_settled(settled), .loop_release_active(rel)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Tests run a few hundred cycles at most
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      $display("wrong value at %0t: run hung", $time);
      close_out();
    end
  end

  task automatic tally(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, $sformatf("read %h expected %h", g, e));
  endtask

  task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, $sformatf("output %h expected %h", g, e));
  endtask

  task automatic chk_len(input int g, input int e);
    tally(g == e, $sformatf("duration %0d expected %0d", g, e));
  endtask

  // Entered just after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge mclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 16);
    if (k >= 16) tally(1'b0, "no ready");
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, {24'h0, e});
  endtask

  // Counts the cycles that a timer output stays high
  task automatic measure(input logic on, output int c);
    int k;
    c = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge mclk);
      if ((on ? rel : busy) === 1'b1) c++;
      else if (c > 0) break;
    end
  endtask

  initial begin
    rst_b = 1'b0;
    req = '0;
    hook = 1'b0;
    first = 1'b0;
    quench = 2'h0;
    adj = 2'h0;
    mini = 2'h0;
    raw = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdchk(AC_ADDR, AC_RST);
    rdchk(C5_ADDR, C5_RST);
    chk_out(32'(cfg.offhook_counter_length), 32'(FOH_128));
    wr(AC_ADDR, 8'hff);
    rdchk(AC_ADDR, 8'h3f);
    chk_out(32'({cfg.double_scale_mode, cfg.ac_impedance_select,
                 cfg.impedance_global}), 32'h3f);
    wr(AC_ADDR, 8'h21);
    rdchk(AC_ADDR, 8'h21);
    chk_out(32'({cfg.double_scale_mode, cfg.ac_impedance_select,
                 cfg.impedance_global}), 32'h02);
    wr(AC_ADDR, 8'h02);
    rdchk(AC_ADDR, 8'h02);
    wr(C5_ADDR, 8'heb);
    rdchk(C5_ADDR, 8'heb);
    chk_out(32'({cfg.raised_scale_mode, cfg.receive_corner_select,
      cfg.line_voltage_zero_force_disable}), 32'h7);
    wr(C5_ADDR, 8'h00);
    chk_out(32'({cfg.raised_scale_mode, cfg.receive_corner_select,
      cfg.line_voltage_zero_force_disable}), 32'h0);
    // Unmapped address answers with an error and reads zero
    apb(1'b0, 8'h00, 32'h0);
    chk_reg({rd[30:0], er}, 32'h1);
    wr(AC_ADDR, 8'h10);
    repeat (2) @(posedge mclk);
    chk_out(32'(cfg.scale_setup_ok), 32'h0);
    adj <= ADJ_TOP;
    repeat (2) @(posedge mclk);
    chk_out(32'({cfg.scale_setup_ok, cfg.pin_voltage_top}), 32'h3);
    rdchk(STAT_ADDR, 8'h18);
    wr(AC_ADDR, 8'h00);
    wr(C5_ADDR, 8'h80);
    mini <= 2'h1;
    repeat (2) @(posedge mclk);
    chk_out(32'(cfg.scale_setup_ok), 32'h0);
    mini <= MINI_LOW;
    repeat (2) @(posedge mclk);
    chk_out(32'(cfg.scale_setup_ok), 32'h1);
    adj <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      wr(C5_ADDR, 8'(k << C5_FOH_LSB));
      hook <= 1'b1;
      measure(1'b0, n);
      chk_len(n, OFF_LEN[k]);
      // Settled is launched by the edge after the one that ended the count
      @(posedge mclk);
      chk_out(32'(settled), 32'h1);
      hook <= 1'b0;
      measure(1'b1, n);
      chk_len(n, ON_T0);
      chk_out(32'(settled), 32'h0);
    end
    for (int k = 0; k < 5; k++) begin
      wr(C5_ADDR, 8'h60 | {4'h0, ON_SEC[k], 3'h0});
      first <= ON_FST[k];
      quench <= ON_Q[k];
      hook <= 1'b1;
      measure(1'b0, n);
      hook <= 1'b0;
      measure(1'b1, n);
      chk_len(n, ON_LEN[k]);
    end
    for (int k = 0; k < 8; k++) begin
      wr(C5_ADDR, 8'h20 | 8'(LV_DIS[k]));
      raw <= LV_IN[k];
      repeat (2) @(posedge mclk);
      chk_out(32'(lv), 32'(LV_EXP[k]));
    end
    close_out();
  end

endmodule
